// *** aneg_arbiter.sv ***
// negotiation arbiter with status registers of a 10/100 physical layer
//
// Behaviour
// - link fail inhibit timer runs 640 ms from the start of the link good check, which begins 50 ms after a technology is chosen
// - minimum burst spacing timer is 4 ms; earlier bursts are still accepted
// - gap above 150 ms splits bursts into unrelated groups
// - four matching bursts set acknowledge, even when closer than 5 ms
// - a burst with a stray pulse restarts the match count
// - link good check stops bursts, ignores link until break timer ends
// - good link with valid partner signals comes well inside the inhibit time
// - software waits about three seconds before judging the outcome
// - basic status bit 5 reports negotiation complete
// - basic status bit 2 is latched low link; read again for current
// - address status bits 7:6 show duplex and 10 Mb/s speed
// - multiple link fault flag in expansion bit 4 latches until read
module aneg_arbiter #(
   parameter int unsigned MS_CYCLES = aneg_pkg::MS_CYCLES
) (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_reset_n,
   input  wire logic                 i_an_enable,
   input  wire logic                 i_an_restart,
   input  wire logic [3:0]           i_local_ability,
   input  wire aneg_pkg::aneg_burst_t i_burst,
   input  wire logic                 i_link_100,
   input  wire logic                 i_link_10,
   input  wire logic                 i_par_fault,
   input  wire logic                 i_reg_rd,
   input  wire logic [4:0]           i_reg_addr,
   output logic                      o_flp_tx_en,
   output logic                      o_ack_bit,
   output logic                      o_burst_early,
   output logic [15:0]               o_reg_rdata,
   output logic                      o_reg_rvalid
);
   aneg_pkg::aneg_state_t state;
   aneg_pkg::aneg_state_t next_state;
   logic [17:0] tick_cnt;
   logic        ms_tick;
   logic [9:0]  gap_ms;
   logic [9:0]  st_ms;
   logic [2:0]  match_cnt;
   logic [15:0] last_word;
   logic        speed10;
   logic        duplex;
   logic        link_latch;
   logic        multi_link_fault_flag;
   logic        link_now;
   logic        chosen_link;
   logic        clean_burst;
   logic        same_word;
   logic        rd_basic;
   logic        rd_expand;
   logic [3:0]  common;

   assign clean_burst = i_burst.done && !i_burst.stray;
   assign same_word   = (i_burst.word == last_word);
   assign common      = i_local_ability & i_burst.word[aneg_pkg::W_100FD:aneg_pkg::W_10HD];
   assign chosen_link = speed10 ? i_link_10 : i_link_100;
   assign link_now    = (state == aneg_pkg::ST_GOOD) && chosen_link;
   assign rd_basic    = i_reg_rd && (i_reg_addr == aneg_pkg::REG_BASIC);
   assign rd_expand   = i_reg_rd && (i_reg_addr == aneg_pkg::REG_EXPAND);
   assign o_flp_tx_en = (state == aneg_pkg::ST_ABILITY) || (state == aneg_pkg::ST_ACK);
   assign ms_tick     = (tick_cnt == 18'(MS_CYCLES - 1));

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tick_cnt <= 18'h00000;
      end else if (ms_tick) begin
         tick_cnt <= 18'h00000;
      end else begin
         tick_cnt <= tick_cnt + 18'h00001;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gap_ms <= aneg_pkg::MS_SAT;
      end else if (i_burst.done) begin
         gap_ms <= 10'h000;
      end else if (ms_tick && gap_ms != aneg_pkg::MS_SAT) begin
         gap_ms <= gap_ms + 10'h001;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_ms <= 10'h000;
      end else if (next_state != state) begin
         st_ms <= 10'h000;
      end else if (ms_tick && st_ms != aneg_pkg::MS_SAT) begin
         st_ms <= st_ms + 10'h001;
      end
   end

   // early bursts are flagged but never rejected
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_burst_early <= 1'b0;
      end else begin
         o_burst_early <= i_burst.done && (gap_ms < aneg_pkg::MIN_TEST_MS);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         match_cnt <= 3'h0;
         last_word <= 16'h0000;
      end else if (state != aneg_pkg::ST_ABILITY || i_an_restart) begin
         match_cnt <= 3'h0;
      end else if (i_burst.done) begin
         last_word <= i_burst.word;
         if (i_burst.stray) begin
            match_cnt <= 3'h0;
         end else if (gap_ms > aneg_pkg::MAX_TEST_MS) begin
            match_cnt <= 3'h1;
         end else if (!same_word) begin
            match_cnt <= 3'h1;
         end else if (match_cnt != aneg_pkg::ACK_COUNT) begin
            match_cnt <= match_cnt + 3'h1;
         end
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         aneg_pkg::ST_IDLE: begin
            if (i_an_enable) begin
               next_state = aneg_pkg::ST_ABILITY;
            end
         end
         aneg_pkg::ST_ABILITY: begin
            if (clean_burst && same_word && gap_ms <= aneg_pkg::MAX_TEST_MS
                && match_cnt == aneg_pkg::ACK_COUNT - 3'h1) begin
               next_state = aneg_pkg::ST_ACK;
            end
         end
         aneg_pkg::ST_ACK: begin
            if (st_ms >= aneg_pkg::LINK_MS) begin
               next_state = aneg_pkg::ST_CHECK;
            end
         end
         aneg_pkg::ST_CHECK: begin
            if (st_ms >= aneg_pkg::BREAK_MS && chosen_link) begin
               next_state = aneg_pkg::ST_GOOD;
            end else if (st_ms >= aneg_pkg::INHIBIT_MS) begin
               next_state = aneg_pkg::ST_ABILITY;
            end
         end
         aneg_pkg::ST_GOOD: begin
            if (!chosen_link) begin
               next_state = aneg_pkg::ST_ABILITY;
            end
         end
         default: begin
            next_state = aneg_pkg::ST_IDLE;
         end
      endcase
      if (!i_an_enable) begin
         next_state = aneg_pkg::ST_IDLE;
      end else if (i_an_restart) begin
         next_state = aneg_pkg::ST_ABILITY;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= aneg_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ack_bit <= 1'b0;
         speed10   <= 1'b0;
         duplex    <= 1'b0;
      end else if (state == aneg_pkg::ST_ABILITY && next_state == aneg_pkg::ST_ACK) begin
         o_ack_bit <= 1'b1;
         speed10   <= !(common[3] || common[2]);
         duplex    <= common[3] || (!common[2] && common[1]);
      end else if (next_state == aneg_pkg::ST_ABILITY || next_state == aneg_pkg::ST_IDLE) begin
         o_ack_bit <= 1'b0;
      end
   end

   // latched low link: a failure wins over the read that refreshes it
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         link_latch <= 1'b0;
      end else if (!link_now) begin
         link_latch <= 1'b0;
      end else if (rd_basic) begin
         link_latch <= 1'b1;
      end
   end

   // fault flag: a new fault wins over the clearing read
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         multi_link_fault_flag <= 1'b0;
      end else if (i_par_fault) begin
         multi_link_fault_flag <= 1'b1;
      end else if (rd_expand) begin
         multi_link_fault_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata  <= 16'h0000;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         o_reg_rdata  <= 16'h0000;
         if (i_reg_rd) begin
            case (i_reg_addr)
               aneg_pkg::REG_BASIC: begin
                  o_reg_rdata[aneg_pkg::BIT_COMPLETE] <= (state == aneg_pkg::ST_GOOD);
                  o_reg_rdata[aneg_pkg::BIT_ABILITY]  <= 1'b1;
                  o_reg_rdata[aneg_pkg::BIT_LINK]     <= link_latch;
               end
               aneg_pkg::REG_EXPAND: begin
                  o_reg_rdata[aneg_pkg::BIT_MLF] <= multi_link_fault_flag;
               end
               aneg_pkg::REG_ADDR_STAT: begin
                  o_reg_rdata[aneg_pkg::BIT_DUPLEX]  <= link_now && duplex;
                  o_reg_rdata[aneg_pkg::BIT_SPEED10] <= link_now && speed10;
               end
               default: begin
                  o_reg_rdata <= 16'h0000;
               end
            endcase
         end
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   property p_tx_off_check;
      state == aneg_pkg::ST_CHECK |-> !o_flp_tx_en
         && (st_ms >= aneg_pkg::BREAK_MS || next_state != aneg_pkg::ST_GOOD);
   endproperty
   a_tx_off_check: assert property (p_tx_off_check)
      else $error("bursts sent or link taken early during link good check");
   property p_inhibit;
      state == aneg_pkg::ST_CHECK && st_ms >= aneg_pkg::INHIBIT_MS && !chosen_link
         && i_an_enable && !i_an_restart |=> state == aneg_pkg::ST_ABILITY;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("inhibit expiry did not restart negotiation");
   property p_ack_four;
      state == aneg_pkg::ST_ABILITY && clean_burst && same_word
         && match_cnt == aneg_pkg::ACK_COUNT - 3'h1
         && gap_ms <= aneg_pkg::MAX_TEST_MS && i_an_enable && !i_an_restart
         |=> state == aneg_pkg::ST_ACK && o_ack_bit;
   endproperty
   a_ack_four: assert property (p_ack_four)
      else $error("fourth matching burst did not acknowledge");
   property p_stray;
      state == aneg_pkg::ST_ABILITY && i_burst.done && i_burst.stray |=> match_cnt == 3'h0;
   endproperty
   a_stray: assert property (p_stray)
      else $error("stray pulse burst was counted");
   property p_alt;
      state == aneg_pkg::ST_ABILITY && clean_burst && !same_word && i_an_enable
         && !i_an_restart |=> match_cnt == 3'h1 && state == aneg_pkg::ST_ABILITY;
   endproperty
   a_alt: assert property (p_alt)
      else $error("alternating code word was counted");
   property p_gap;
      state == aneg_pkg::ST_ABILITY && clean_burst && gap_ms > aneg_pkg::MAX_TEST_MS
         && i_an_enable && !i_an_restart |=> match_cnt == 3'h1;
   endproperty
   a_gap: assert property (p_gap)
      else $error("groups across a long gap were joined");
   property p_mlf_hold;
      multi_link_fault_flag && !rd_expand |=> multi_link_fault_flag;
   endproperty
   a_mlf_hold: assert property (p_mlf_hold)
      else $error("fault flag lost before read");
   property p_complete;
      rd_basic && state == aneg_pkg::ST_GOOD
         |=> o_reg_rvalid && o_reg_rdata[aneg_pkg::BIT_COMPLETE];
   endproperty
   a_complete: assert property (p_complete)
      else $error("complete bit not reported in good state");
   property p_link_latch;
      !link_now ##1 rd_basic |=> o_reg_rvalid && !o_reg_rdata[aneg_pkg::BIT_LINK];
   endproperty
   a_link_latch: assert property (p_link_latch)
      else $error("link failure not latched low");
endmodule

// *** aneg_pkg.sv ***
// constants, types and register layout for the negotiation arbiter
package aneg_pkg;
   localparam int unsigned CLK_MHZ       = 250;
   localparam int unsigned MS_US         = 1000;
   localparam int unsigned MS_CYCLES     = CLK_MHZ * MS_US;
   localparam logic [9:0]  MIN_TEST_MS   = 10'h004;
   localparam logic [9:0]  MAX_TEST_MS   = 10'h096;
   localparam logic [9:0]  INHIBIT_MS    = 10'h280;
   localparam logic [9:0]  BREAK_MS      = 10'h03c;
   localparam logic [9:0]  LINK_MS       = 10'h032;
   localparam logic [9:0]  MS_SAT        = 10'h3ff;
   localparam logic [2:0]  ACK_COUNT     = 3'h4;
   localparam logic [4:0]  REG_BASIC     = 5'h01;
   localparam logic [4:0]  REG_EXPAND    = 5'h06;
   localparam logic [4:0]  REG_ADDR_STAT = 5'h19;
   localparam int unsigned BIT_COMPLETE  = 5;
   localparam int unsigned BIT_ABILITY   = 3;
   localparam int unsigned BIT_LINK      = 2;
   localparam int unsigned BIT_MLF       = 4;
   localparam int unsigned BIT_DUPLEX    = 7;
   localparam int unsigned BIT_SPEED10   = 6;
   localparam int unsigned W_100FD       = 8;
   localparam int unsigned W_100HD       = 7;
   localparam int unsigned W_10FD        = 6;
   localparam int unsigned W_10HD        = 5;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_ABILITY = 5'h02,
      ST_ACK     = 5'h04,
      ST_CHECK   = 5'h08,
      ST_GOOD    = 5'h10
   } aneg_state_t;

   typedef struct packed {
      logic        done;
      logic        stray;
      logic [15:0] word;
   } aneg_burst_t;
endpackage

// *** aneg_lp_model.sv ***
// link partner model that repeats one code word burst at a set spacing
module aneg_lp_model (
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset_n,
   input  wire logic             i_send,
   input  wire logic             i_stray_next,
   input  wire logic [15:0]      i_word,
   input  wire logic [15:0]      i_gap,
   output aneg_pkg::aneg_burst_t o_burst
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt;
   logic        armed;
   // pulse timing inside a burst is abstracted to one done strobe per burst
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt     <= 16'h0000;
         armed   <= 1'b0;
         o_burst <= '0;
      end else if (i_send && cnt + 16'h0001 >= i_gap) begin
         cnt     <= 16'h0000;
         armed   <= 1'b0;
         o_burst <= {1'b1, armed || i_stray_next, i_word};
      end else begin
         cnt     <= i_send ? cnt + 16'h0001 : 16'h0000;
         armed   <= armed || i_stray_next;
         // word is not held between bursts
         o_burst <= {1'b0, 1'b0, ~o_burst.word};
      end
   end
endmodule

// *** test_aneg_arbiter.sv ***
// self-checking bench for the negotiation arbiter
module test_aneg_arbiter;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 10;
   localparam int G = 16 * MS;
   logic                  i_clk_sys, i_reset_n, i_an_enable, i_an_restart, i_link_100;
   logic                  i_link_10, i_par_fault, i_reg_rd, lp_send, lp_stray, alt;
   logic                  o_flp_tx_en, o_ack_bit, o_burst_early, o_reg_rvalid;
   logic [3:0]            i_local_ability, partner;
   logic [4:0]            i_reg_addr;
   logic [15:0]           o_reg_rdata, lp_word, lp_gap;
   logic [15:0]           exp_q[$];
   aneg_pkg::aneg_burst_t i_burst;
   int                    failures, cmp_count, early_cnt;

   aneg_arbiter #(.MS_CYCLES(MS)) dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .i_an_enable(i_an_enable), .i_an_restart(i_an_restart),
      .i_local_ability(i_local_ability), .i_burst(i_burst), .i_link_100(i_link_100),
      .i_link_10(i_link_10), .i_par_fault(i_par_fault), .i_reg_rd(i_reg_rd),
      .i_reg_addr(i_reg_addr), .o_flp_tx_en(o_flp_tx_en), .o_ack_bit(o_ack_bit),
      .o_burst_early(o_burst_early), .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid));
   aneg_lp_model lp_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_send(lp_send),
      .i_stray_next(lp_stray), .i_word(lp_word), .i_gap(lp_gap), .o_burst(i_burst));

   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   task automatic summarize();
      $display("failures=%0d comparisons=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      exp_q.push_back(e);
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
   endtask

   task automatic restart();
      @(posedge i_clk_sys);
      lp_send <= 1'b0;
      i_an_restart <= 1'b1;
      @(posedge i_clk_sys);
      i_an_restart <= 1'b0;
      cyc(2);
      chk(o_ack_bit, 1'b0);
   endtask

   task automatic bursts(input int gap, input int n);
      @(posedge i_clk_sys);
      lp_gap <= 16'(gap);
      lp_send <= 1'b1;
      cyc(n * gap + 3);
   endtask

   task automatic wait_ack();
      int k;
      k = 0;
      while (o_ack_bit !== 1'b1 && k < 20) begin
         @(posedge i_clk_sys);
         k++;
      end
      chk(o_ack_bit, 1'b1);
      lp_send <= 1'b0;
   endtask

   function automatic logic [15:0] exp_sel(input logic [3:0] c);
      if (c[3]) return 16'h0080;
      else if (c[2]) return 16'h0000;
      else if (c[1]) return 16'h00c0;
      return 16'h0040;
   endfunction

   always @(posedge i_clk_sys) begin
      if (o_reg_rvalid === 1'b1) cmp_rd(o_reg_rdata, exp_q.pop_front());
      if (o_burst_early === 1'b1) early_cnt++;
      if (alt && i_burst.done === 1'b1) lp_word <= lp_word ^ 16'h0180;
   end

   initial begin
      repeat (90000) @(posedge i_clk_sys);
      failures++;
      summarize();
   end

   initial begin
      void'($urandom(87639));
      partner = 4'($urandom_range(15, 1));
      {i_reset_n, i_an_restart, i_link_100, i_link_10, i_par_fault} = 5'h00;
      {i_reg_rd, lp_send, lp_stray, alt} = 4'h0;
      i_an_enable = 1'b1;
      i_reg_addr = 5'h00;
      i_local_ability = 4'($urandom);
      lp_gap = 16'(G);
      lp_word = {7'($urandom), partner, 5'($urandom)};
      {failures, cmp_count, early_cnt} = '0;
      cyc(8);
      i_reset_n <= 1'b1;
      cyc(2);
      chk(o_flp_tx_en, 1'b1);
      rd(aneg_pkg::REG_BASIC, 16'h0008);
      rd(aneg_pkg::REG_EXPAND, 16'h0000);
      rd(aneg_pkg::REG_ADDR_STAT, 16'h0000);
      rd(5'h1f, 16'h0000);
      bursts(160 * MS, 5);
      chk(o_ack_bit, 1'b0);
      restart();
      alt <= 1'b1;
      bursts(G, 8);
      chk(o_ack_bit, 1'b0);
      alt <= 1'b0;
      restart();
      bursts(G, 2);
      lp_stray <= 1'b1;
      cyc(1);
      lp_stray <= 1'b0;
      cyc(4 * G);
      chk(o_ack_bit, 1'b0);
      cyc(G);
      chk(o_ack_bit, 1'b1);
      restart();
      early_cnt = 0;
      bursts(3 * MS, 4);
      wait_ack();
      chk(1'(early_cnt >= 3), 1'b1);
      {i_link_100, i_link_10} <= 2'b11;
      restart();
      bursts(G, 4);
      wait_ack();
      cyc(60 * MS);
      chk(o_flp_tx_en, 1'b0);
      rd(aneg_pkg::REG_BASIC, 16'h0008);
      cyc(140 * MS);
      rd(aneg_pkg::REG_BASIC, 16'h0028);
      rd(aneg_pkg::REG_BASIC, 16'h002c);
      cyc(2800 * MS);
      rd(aneg_pkg::REG_BASIC, 16'h002c);
      rd(aneg_pkg::REG_ADDR_STAT, exp_sel(i_local_ability & partner));
      i_par_fault <= 1'b1;
      cyc(1);
      i_par_fault <= 1'b0;
      rd(aneg_pkg::REG_EXPAND, 16'h0010);
      rd(aneg_pkg::REG_EXPAND, 16'h0000);
      {i_link_100, i_link_10} <= 2'b00;
      restart();
      bursts(G, 4);
      wait_ack();
      cyc(680 * MS);
      chk(o_flp_tx_en, 1'b0);
      cyc(20 * MS);
      chk(o_flp_tx_en, 1'b1);
      i_an_enable <= 1'b0;
      cyc(2);
      chk(o_flp_tx_en, 1'b0);
      chk(o_ack_bit, 1'b0);
      chk(1'(exp_q.size() == 0), 1'b1);
      summarize();
   end
endmodule
